// ---- design/tmr3cc_defines.svh ----
// register offsets, field positions, reset values and divider counts of the third timer
`ifndef TMR3CC_DEFINES_SVH
`define TMR3CC_DEFINES_SVH
`define TMR3_ADDR_ACTION   8'h90
`define TMR3_ADDR_EDGEPS   8'h91
`define TMR3_ADDR_CNT_HI   8'h92
`define TMR3_ADDR_CNT_LO   8'h93
`define TMR3_ADDR_CMP_BASE 8'h94
`define TMR3_ADDR_MASK     8'h9C
`define TMR3_ADDR_FLAGS    8'h9D
`define TMR3_CTRL_RESET    8'h00
`define TMR3_CNT_RESET     16'h0000
`define TMR3_CNT_PRESET    16'hFFF8
`define TMR3_CNT_MAX       16'hFFFF
`define TMR3_CMP_RESET     16'hFFFF
`define TMR3_BIT_SELECT    0
`define TMR3_BIT_STOP      1
`define TMR3_FLD_EVENT     3:2
`define TMR3_FLD_PRESCALE  5:4
`define TMR3_FLD_CAPEDGE   7:6
`define TMR3_BIT_OVF       3
`define TMR3_DIV4_LAST     2'h3
`define TMR3_DIV16_LAST    4'hF
`endif

// ---- design/tmr3cc_pkg.sv ----
// types of the third timer
package tmr3cc_pkg;
	typedef enum logic [1:0] {
		TMR3_PS_TIMER1 = 2'b00,
		TMR3_PS_DIV1   = 2'b01,
		TMR3_PS_DIV4   = 2'b10,
		TMR3_PS_DIV16  = 2'b11
	} tmr3cc_prescale_t;
	typedef enum logic [1:0] {
		TMR3_EDGE_NONE = 2'b00,
		TMR3_EDGE_RISE = 2'b01,
		TMR3_EDGE_FALL = 2'b10,
		TMR3_EDGE_ANY  = 2'b11
	} tmr3cc_edge_t;
	typedef enum logic [1:0] {
		TMR3_ACT_OFF    = 2'b00,
		TMR3_ACT_TOGGLE = 2'b01,
		TMR3_ACT_LOW    = 2'b10,
		TMR3_ACT_HIGH   = 2'b11
	} tmr3cc_action_t;
endpackage

// ---- design/tmr3cc_top.sv ----
// third timer: free counter, four compare channels, capture on channel four
`timescale 1ns/1ns
`include "tmr3cc_defines.svh"
// Summary of operation
// - counter always readable; normal mode: write to either byte clears it
// - special test mode: write to high byte presets counter to FFF8
// - high byte read latches low byte for the next cycle's read
// - counter resets to zero
// - two-bit action per channel: off, toggle, drive low, drive high
// - select bit 0 picks capture or compare for channel four
// - capture edge field: off, rising, falling, any; only in capture mode
// - prescale field: first timer rate, divide by 1, 4, 16
// - prescale field accepts only its first write after reset
// - event field: internal clock, or rising, falling, any external edge
// - event field accepts only its first write after reset
// - stop bit halts counter and prescaler, holds count at zero
// - mask bits 7 to 3 gate the matching flag bits
// - three compare and channel four sources share one request
// - channel four enable serves capture or compare by mode
// - overflow flag and its enable raise a separate request
// - bits 2 to 0 of mask and flags read zero
// - writing one clears a flag, zero leaves it
// - compare flags set when counter equals compare register
// - channel four flag set by compare match or selected capture edge
// - overflow flag set when counter wraps from FFFF to zero
// - write to compare high byte inhibits compare for one cycle
// - compare and channel four registers reset to all ones
module tmr3cc_top (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       reset,
	// register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rd_data,
	// chip context
	input  wire logic       special_test_mode,
	input  wire logic       timer1_tick,
	// pins
	input  wire logic       event_clock_pin,
	input  wire logic       channel_four_pin,
	output logic      [3:0] compare_pin_out,
	output logic      [3:0] compare_pin_oe,
	// requests
	output logic            irq_compare,
	output logic            irq_overflow
);
	logic [7:0]  action_q;
	logic [7:0]  edgeps_q;
	logic        ps_locked_q;
	logic        ev_locked_q;
	logic [7:0]  mask_q;
	logic [7:0]  flags_q;
	logic [15:0] cnt_q;
	logic        cnt_new_q;
	logic [7:0]  lo_buf_q;
	logic        lo_buf_valid_q;
	logic [3:0]  ps_cnt_q;
	logic [2:0]  ev_sync_q;
	logic [2:0]  cap_sync_q;
	logic [7:0]  rd_data_q;
	logic [7:0]  rd_mux;
	logic        tick;
	logic        ev_edge;
	logic        cap_ev;
	logic        ch4_capture;
	logic        stop;
	logic        wr_cnt;
	logic        ovf_ev;
	logic [3:0]  match;
	logic [7:0]  flag_set;
	logic [15:0] cmp_val [4];

	assign ch4_capture = edgeps_q[`TMR3_BIT_SELECT];
	assign stop = edgeps_q[`TMR3_BIT_STOP];
	assign wr_cnt = wr_en && (addr == `TMR3_ADDR_CNT_HI || addr == `TMR3_ADDR_CNT_LO);

	// control registers, write-once fields locked by first write
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			action_q    <= `TMR3_CTRL_RESET;
			edgeps_q    <= `TMR3_CTRL_RESET;
			ps_locked_q <= 1'b0;
			ev_locked_q <= 1'b0;
			mask_q      <= `TMR3_CTRL_RESET;
		end else if (wr_en) begin
			if (addr == `TMR3_ADDR_ACTION)
				action_q <= wr_data;
			if (addr == `TMR3_ADDR_MASK)
				mask_q <= {wr_data[7:3], 3'h0};
			if (addr == `TMR3_ADDR_EDGEPS) begin
				edgeps_q[`TMR3_FLD_CAPEDGE] <= wr_data[`TMR3_FLD_CAPEDGE];
				edgeps_q[1:0] <= wr_data[1:0];
				ps_locked_q <= 1'b1;
				ev_locked_q <= 1'b1;
				if (!ps_locked_q)
					edgeps_q[`TMR3_FLD_PRESCALE] <= wr_data[`TMR3_FLD_PRESCALE];
				if (!ev_locked_q)
					edgeps_q[`TMR3_FLD_EVENT] <= wr_data[`TMR3_FLD_EVENT];
			end
		end
	end

	// pin synchronisers, third stage only for edge detection
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			ev_sync_q  <= 3'h0;
			cap_sync_q <= 3'h0;
		end else begin
			ev_sync_q  <= {ev_sync_q[1:0], event_clock_pin};
			cap_sync_q <= {cap_sync_q[1:0], channel_four_pin};
		end
	end

	// external edge selection for event counting and capture
	always_comb begin
		unique case (tmr3cc_pkg::tmr3cc_edge_t'(edgeps_q[`TMR3_FLD_EVENT]))
			tmr3cc_pkg::TMR3_EDGE_NONE: ev_edge = 1'b0;
			tmr3cc_pkg::TMR3_EDGE_RISE: ev_edge = ev_sync_q[1] && !ev_sync_q[2];
			tmr3cc_pkg::TMR3_EDGE_FALL: ev_edge = !ev_sync_q[1] && ev_sync_q[2];
			tmr3cc_pkg::TMR3_EDGE_ANY:  ev_edge = ev_sync_q[1] ^ ev_sync_q[2];
		endcase
		unique case (tmr3cc_pkg::tmr3cc_edge_t'(edgeps_q[`TMR3_FLD_CAPEDGE]))
			tmr3cc_pkg::TMR3_EDGE_NONE: cap_ev = 1'b0;
			tmr3cc_pkg::TMR3_EDGE_RISE: cap_ev = cap_sync_q[1] && !cap_sync_q[2];
			tmr3cc_pkg::TMR3_EDGE_FALL: cap_ev = !cap_sync_q[1] && cap_sync_q[2];
			tmr3cc_pkg::TMR3_EDGE_ANY:  cap_ev = cap_sync_q[1] ^ cap_sync_q[2];
		endcase
		cap_ev = cap_ev && ch4_capture;
	end

	// prescaler, halted and cleared by stop
	always_ff @(posedge sys_clk) begin
		if (reset || stop)
			ps_cnt_q <= 4'h0;
		else
			ps_cnt_q <= ps_cnt_q + 4'h1;
	end

	// counter clock source
	always_comb begin
		unique case (tmr3cc_pkg::tmr3cc_prescale_t'(edgeps_q[`TMR3_FLD_PRESCALE]))
			tmr3cc_pkg::TMR3_PS_TIMER1: tick = timer1_tick;
			tmr3cc_pkg::TMR3_PS_DIV1:   tick = 1'b1;
			tmr3cc_pkg::TMR3_PS_DIV4:   tick = ps_cnt_q[1:0] == `TMR3_DIV4_LAST;
			tmr3cc_pkg::TMR3_PS_DIV16:  tick = ps_cnt_q == `TMR3_DIV16_LAST;
		endcase
		if (edgeps_q[`TMR3_FLD_EVENT] != 2'b00)
			tick = ev_edge;
		tick = tick && !stop;
	end

	assign ovf_ev = tick && !wr_cnt && cnt_q == `TMR3_CNT_MAX;

	// free counter
	always_ff @(posedge sys_clk) begin
		if (reset || stop) begin
			cnt_q     <= `TMR3_CNT_RESET;
			cnt_new_q <= 1'b0;
		end else if (wr_cnt) begin
			cnt_new_q <= 1'b0;
			if (special_test_mode && addr == `TMR3_ADDR_CNT_HI)
				cnt_q <= `TMR3_CNT_PRESET;
			else
				cnt_q <= `TMR3_CNT_RESET;
		end else begin
			cnt_new_q <= tick;
			if (tick)
				cnt_q <= cnt_q + 16'h0001;
		end
	end

	// low byte buffer for coherent two-byte read
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			lo_buf_q       <= 8'h00;
			lo_buf_valid_q <= 1'b0;
		end else begin
			lo_buf_valid_q <= rd_en && addr == `TMR3_ADDR_CNT_HI;
			if (rd_en && addr == `TMR3_ADDR_CNT_HI)
				lo_buf_q <= cnt_q[7:0];
		end
	end

	// compare channels
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_ch
			localparam logic [7:0] HI_ADDR = `TMR3_ADDR_CMP_BASE + 8'(2 * i);
			localparam logic [7:0] LO_ADDR = HI_ADDR + 8'h01;
			logic [15:0] cmp_q;
			logic        inhibit_q;
			logic        pin_q;
			logic [1:0]  act;
			assign act = action_q[7 - 2 * i -: 2];
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					cmp_q     <= `TMR3_CMP_RESET;
					inhibit_q <= 1'b0;
				end else begin
					inhibit_q <= wr_en && addr == HI_ADDR;
					if (i == 3 && cap_ev)
						cmp_q <= cnt_q;
					else if (wr_en && addr == HI_ADDR)
						cmp_q[15:8] <= wr_data;
					else if (wr_en && addr == LO_ADDR)
						cmp_q[7:0] <= wr_data;
				end
			end
			assign match[i] = cnt_new_q && !inhibit_q && cnt_q == cmp_q
				&& !(i == 3 && ch4_capture);
			assign cmp_val[i] = cmp_q;
			always_ff @(posedge sys_clk) begin
				if (reset)
					pin_q <= 1'b0;
				else if (match[i]) begin
					unique case (tmr3cc_pkg::tmr3cc_action_t'(act))
						tmr3cc_pkg::TMR3_ACT_OFF:    pin_q <= pin_q;
						tmr3cc_pkg::TMR3_ACT_TOGGLE: pin_q <= !pin_q;
						tmr3cc_pkg::TMR3_ACT_LOW:    pin_q <= 1'b0;
						tmr3cc_pkg::TMR3_ACT_HIGH:   pin_q <= 1'b1;
					endcase
				end
			end
			assign compare_pin_out[i] = pin_q;
			assign compare_pin_oe[i]  = act != 2'b00 && !(i == 3 && ch4_capture);
		end
	endgenerate

	// event flags, set wins over clear
	assign flag_set = {match[0], match[1], match[2], ch4_capture ? cap_ev : match[3],
		ovf_ev, 3'h0};
	always_ff @(posedge sys_clk) begin
		if (reset)
			flags_q <= `TMR3_CTRL_RESET;
		else if (wr_en && addr == `TMR3_ADDR_FLAGS)
			flags_q <= (flags_q & ~{wr_data[7:3], 3'h0}) | flag_set;
		else
			flags_q <= flags_q | flag_set;
	end

	assign irq_compare  = |(mask_q[7:4] & flags_q[7:4]);
	assign irq_overflow = mask_q[`TMR3_BIT_OVF] && flags_q[`TMR3_BIT_OVF];

	// read data
	always_comb begin
		rd_mux = 8'h00;
		unique case (addr)
			`TMR3_ADDR_ACTION: rd_mux = action_q;
			`TMR3_ADDR_EDGEPS: rd_mux = edgeps_q;
			`TMR3_ADDR_CNT_HI: rd_mux = cnt_q[15:8];
			`TMR3_ADDR_CNT_LO: rd_mux = lo_buf_valid_q ? lo_buf_q : cnt_q[7:0];
			`TMR3_ADDR_MASK:   rd_mux = mask_q;
			`TMR3_ADDR_FLAGS:  rd_mux = flags_q;
			default:           rd_mux = 8'h00;
		endcase
		for (int k = 0; k < 4; k++) begin
			if (addr == `TMR3_ADDR_CMP_BASE + 8'(2 * k))
				rd_mux = cmp_val[k][15:8];
			if (addr == `TMR3_ADDR_CMP_BASE + 8'(2 * k + 1))
				rd_mux = cmp_val[k][7:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset || !rd_en)
			rd_data_q <= 8'h00;
		else
			rd_data_q <= rd_mux;
	end
	assign rd_data = rd_data_q;

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	a_ctr_write_clear: assert property (
		wr_en && addr == `TMR3_ADDR_CNT_LO |=> cnt_q == 16'h0000)
		else $error("counter not cleared by write");
	a_ctr_test_preset: assert property (
		wr_en && addr == `TMR3_ADDR_CNT_HI && special_test_mode && !stop
		|=> cnt_q == 16'hFFF8)
		else $error("counter not preset in test mode");
	a_read_coherent: assert property (
		rd_en && addr == `TMR3_ADDR_CNT_HI ##1 rd_en && addr == `TMR3_ADDR_CNT_LO
		|=> rd_data == $past(cnt_q[7:0], 2))
		else $error("low byte not coherent with high byte");
	a_stop_holds: assert property (
		stop [*2] |-> cnt_q == 16'h0000 && ps_cnt_q == 4'h0)
		else $error("counter runs while stopped");
	a_prescale_lock: assert property (
		ps_locked_q && wr_en && addr == `TMR3_ADDR_EDGEPS
		|=> $stable(edgeps_q[5:4]))
		else $error("prescale field rewritten");
	a_event_lock: assert property (
		ev_locked_q && wr_en && addr == `TMR3_ADDR_EDGEPS
		|=> $stable(edgeps_q[3:2]))
		else $error("event field rewritten");
	a_flag_clear: assert property (
		wr_en && addr == `TMR3_ADDR_FLAGS && wr_data[7] && !match[0] |=> !flags_q[7])
		else $error("flag not cleared by one");
	a_ovf_flag_set: assert property (
		ovf_ev |=> flags_q[3] && cnt_q == 16'h0000)
		else $error("overflow not flagged");
	a_ovf_request: assert property (
		flags_q[3] && mask_q[3] |-> irq_overflow)
		else $error("overflow request missing");
	a_cmp_inhibit: assert property (
		wr_en && addr == `TMR3_ADDR_CMP_BASE |=> !match[0])
		else $error("compare not inhibited");
	a_capture_copy: assert property (
		cap_ev |=> cmp_val[3] == $past(cnt_q) && flags_q[4])
		else $error("capture did not copy counter");
	a_unimpl_zero: assert property (
		rd_en && (addr == `TMR3_ADDR_FLAGS || addr == `TMR3_ADDR_MASK)
		|=> rd_data[2:0] == 3'h0)
		else $error("unimplemented bits not zero");
	a_cmp_request: assert property (
		flags_q[7] && mask_q[7] |-> irq_compare)
		else $error("compare request missing");
	a_match_flag: assert property (
		match[1] |=> flags_q[6])
		else $error("compare match not flagged");
	a_action_high: assert property (
		match[0] && action_q[7:6] == 2'b11 |=> compare_pin_out[0])
		else $error("pin not driven high on match");
	a_ch4_mode_split: assert property (
		ch4_capture |-> !match[3] && !compare_pin_oe[3])
		else $error("channel four compare active in capture mode");
	a_flag_sticky: assert property (
		flags_q[7] && !(wr_en && addr == `TMR3_ADDR_FLAGS && wr_data[7]) |=> flags_q[7])
		else $error("flag lost without a clear");

	c_overflow: cover property (ovf_ev);
	c_capture: cover property (cap_ev);
	c_match_toggle: cover property (match[0] && action_q[7:6] == 2'b01);
	c_coherent_read: cover property (rd_en && addr == `TMR3_ADDR_CNT_HI ##1 rd_en);
	c_test_preset: cover property (wr_cnt && special_test_mode);
endmodule

// ---- sim/tb_top.sv ----
// register level tests of the third timer
`timescale 1ns/1ns
module tb_top;
	logic       sys_clk, reset, wr_en, rd_en, stm, tick, evt_run, cap_lvl;
	logic       evt_pin, cap_pin, irq_c, irq_o;
	logic [7:0] addr, wr_data, rd_data, d, lo;
	logic [3:0] pin_out, pin_oe;
	int         n_errors, tests_run;
	logic [7:0] radr [9] = '{8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h9B, 8'h9C, 8'h9D, 8'hA0};
	logic [7:0] rexp [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	tmr3cc_top tmr3cc_top_inst (.sys_clk(sys_clk), .reset(reset), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.special_test_mode(stm), .timer1_tick(tick), .event_clock_pin(evt_pin),
		.channel_four_pin(cap_pin), .compare_pin_out(pin_out), .compare_pin_oe(pin_oe),
		.irq_compare(irq_c), .irq_overflow(irq_o));
	tmr3cc_pin_model tmr3cc_pin_model_inst (.sys_clk(sys_clk), .evt_run(evt_run),
		.cap_lvl(cap_lvl), .event_clock_pin(evt_pin), .channel_four_pin(cap_pin));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= v;
		@(posedge sys_clk);
		wr_en <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd_en <= 1'b0;
		@(posedge sys_clk);
		v = rd_data;
	endtask
	// back to back pair of reads, data taken at the edge after each strobe
	task automatic rd2(input logic [7:0] a0, input logic [7:0] a1,
		output logic [7:0] v0, output logic [7:0] v1);
		rd_en <= 1'b1;
		addr <= a0;
		@(posedge sys_clk);
		addr <= a1;
		@(posedge sys_clk);
		v0 = rd_data;
		rd_en <= 1'b0;
		@(posedge sys_clk);
		v1 = rd_data;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk(v, e);
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic do_reset();
		reset <= 1'b1;
		wait_n(2);
		reset <= 1'b0;
		wait_n(1);
	endtask
	task automatic final_report();
		$display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (3000) @(posedge sys_clk);
		n_errors++;
		final_report();
	end

	initial begin
		reset = 1'b1;
		{wr_en, rd_en, stm, tick, evt_run, cap_lvl} = 6'h00;
		addr = 8'h00;
		wr_data = 8'h00;
		n_errors = 0;
		tests_run = 0;
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		wait_n(1);
		// reset values and an unmapped address
		foreach (radr[i]) rc(radr[i], rexp[i]);
		$display("test 1 done");
		// actions high, low, toggle, off; compares at FFFC..FFFE
		wr(8'h90, 8'hE4);
		for (int i = 0; i < 3; i++) begin
			wr(8'(8'h94 + 2 * i), 8'hFF);
			wr(8'(8'h95 + 2 * i), 8'(8'hFC + i));
		end
		wr(8'h9C, 8'hFF);
		rc(8'h9C, 8'hF8);
		wr(8'h91, 8'h12);
		rc(8'h92, 8'h00);
		rc(8'h93, 8'h00);
		rc(8'h91, 8'h12);
		wr(8'h91, 8'h3C);
		rc(8'h91, 8'h10);
		evt_run <= 1'b1;
		rd2(8'h92, 8'h93, d, lo);
		rd(8'h93, d);
		chk(8'(d - lo), 16'h0003);
		$display("test 2 done");
		stm <= 1'b1;
		wr(8'h92, 8'h00);
		stm <= 1'b0;
		wait_n(20);
		rc(8'h9D, 8'hF8);
		chk(pin_out, 4'b0101);
		chk(pin_oe, 4'b0111);
		chk({irq_c, irq_o}, 2'b11);
		wr(8'h9D, 8'h08);
		rc(8'h9D, 8'hF0);
		chk(irq_o, 1'b0);
		wr(8'h9C, 8'h08);
		chk(irq_c, 1'b0);
		wr(8'h9D, 8'hFF);
		rc(8'h9D, 8'h00);
		$display("test 3 done");
		stm <= 1'b1;
		wr(8'h92, 8'h00);
		stm <= 1'b0;
		wr(8'h93, 8'h00);
		rc(8'h92, 8'h00);
		$display("test 4 done");
		// capture on rising edges with the counter running
		wr(8'h91, 8'h41);
		wr(8'h90, 8'hFF);
		wr(8'h9C, 8'h10);
		wr(8'h9A, 8'h12);
		wr(8'h9B, 8'h34);
		cap_lvl <= 1'b1;
		rd2(8'h92, 8'h93, d, lo);
		wait_n(3);
		rc(8'h9A, 8'(({d, lo} + 16'h0003) >> 8));
		rc(8'h9B, 8'(lo + 8'h03));
		rc(8'h9D, 8'h10);
		chk(irq_c, 1'b1);
		chk(pin_oe[3], 1'b0);
		wr(8'h9D, 8'hFF);
		cap_lvl <= 1'b0;
		wait_n(6);
		rc(8'h9D, 8'h00);
		$display("test 5 done");
		// second reset, first timer rate, then divide by 16
		do_reset();
		tick <= 1'b1;
		wait_n(3);
		tick <= 1'b0;
		rc(8'h93, 8'h03);
		wr(8'h91, 8'h30);
		rd(8'h93, lo);
		wait_n(30);
		rd(8'h93, d);
		chk(8'(d - lo), 16'h0002);
		$display("test 6 done");
		// third reset, then count rising edges of the external clock
		do_reset();
		wr(8'h91, 8'h04);
		rd(8'h93, lo);
		wait_n(30);
		rd(8'h93, d);
		chk(8'(d - lo), 16'h0004);
		$display("test 7 done");
		final_report();
	end
endmodule

// ---- sim/tmr3cc_pin_model.sv ----
// far side of the third timer: external count clock source and channel four pin driver
`timescale 1ns/1ns
module tmr3cc_pin_model (
	// clock
	input  wire logic sys_clk,
	// commands from the bench
	input  wire logic evt_run,
	input  wire logic cap_lvl,
	// pins into the timer
	output logic      event_clock_pin,
	output logic      channel_four_pin
);
	logic [2:0] div_q;
	initial begin
		event_clock_pin = 1'b0;
		channel_four_pin = 1'b0;
		div_q = 3'h0;
	end
	// count clock changes every 4 bus cycles and stands still while not running
	always @(posedge sys_clk) begin
		div_q <= div_q + 3'h1;
		if (evt_run && div_q[1:0] == 2'h3) begin
			event_clock_pin <= ~event_clock_pin;
		end
		channel_four_pin <= cap_lvl;
	end
endmodule
